// ---- verilog/pllc_top.sv ----
// PLL clock controller: APB register file, lock supervision, pending
// post-dividers applied by the go command, and system clock enables.
// Assumes the controller clock stands in for the multiplied output;
// the analog loop itself lives outside this block.
//
// Register access over APB is this design's own decision.
`timescale 1ns/100ps

module pllc_top #(
  parameter int LOCK_CYCLES = pllc_pkg::LOCK_CYCLES
) (
  input  wire logic               clk,
  input  wire logic               reset_n,
  input  wire logic               psel,
  input  wire logic               penable,
  input  wire logic               pwrite,
  input  wire logic [31:0]        paddr,
  input  wire logic [31:0]        pwdata,
  output logic [31:0]             prdata,
  output logic                    pready,
  output logic                    pslverr,
  output logic                    loop_reset_ctl,
  output logic                    loop_path_enable,
  output logic [4:0]              multiplier_factor,
  output logic [4:0]              pre_divider,
  output pllc_pkg::pllc_sysclk_type sys_clk_en
);
  localparam int RW = pllc_pkg::RATIO_W;

  // Peripheral ratio must be exactly two, three or four core periods.
  function automatic logic ratio_ok(input logic [RW-1:0] c, input logic [RW-1:0] p);
    logic [7:0] cn;
    logic [7:0] pn;
    cn = 8'(c) + 8'h01;
    pn = 8'(p) + 8'h01;
    return (pn == 8'(cn * 2)) || (pn == 8'(cn * 3)) || (pn == 8'(cn * 4));
  endfunction : ratio_ok

  logic [31:0]              prdata_r;
  logic                     pready_r;
  logic                     pslverr_r;
  logic                     rst_ctl_r;
  logic                     enable_r;
  logic [4:0]               mult_r;
  logic [RW-1:0]            pre_r;
  pllc_pkg::pllc_ratio_type pend_r;
  pllc_pkg::pllc_ratio_type act_r;
  logic [2:0]               aln_r;
  logic [2:0]               clock_enable_control_r;
  logic                     go_pend_r;
  logic                     merr_r;
  logic                     rerr_r;
  logic                     serr_r;
  logic [3:0]               rst_cnt_r;
  logic                     applied_r;
  pllc_pkg::pllc_sysclk_type sys_r;
  pllc_pkg::pllc_sysclk_type tick;
  logic                     lock_done;

  // Bus decode.
  wire setup   = psel && !penable;
  wire wr_acc  = psel && penable && pready_r && pwrite;
  wire hit_pid  = (paddr == pllc_pkg::ADDR_PID);
  wire hit_csr  = (paddr == pllc_pkg::ADDR_CSR);
  wire hit_mult = (paddr == pllc_pkg::ADDR_MULT);
  wire hit_div0 = (paddr == pllc_pkg::ADDR_DIV0);
  wire hit_div1 = (paddr == pllc_pkg::ADDR_DIV1);
  wire hit_div2 = (paddr == pllc_pkg::ADDR_DIV2);
  wire hit_div3 = (paddr == pllc_pkg::ADDR_DIV3);
  wire hit_cmd  = (paddr == pllc_pkg::ADDR_CMD);
  wire hit_stat = (paddr == pllc_pkg::ADDR_STAT);
  wire hit_aln  = (paddr == pllc_pkg::ADDR_ALN);
  wire hit_clock_enable_control = (paddr == pllc_pkg::ADDR_CLOCK_ENABLE_CONTROL);
  wire hit_ckst = (paddr == pllc_pkg::ADDR_CKST);
  wire hit_syst = (paddr == pllc_pkg::ADDR_SYST);
  wire mapped  = hit_pid | hit_csr | hit_mult | hit_div0 | hit_div1 | hit_div2 |
                 hit_div3 | hit_cmd | hit_stat | hit_aln | hit_clock_enable_control | hit_ckst | hit_syst;

  // Write strobes and their side effects.
  wire [4:0] mult_wr   = pwdata[4:0];
  wire mult_in_range  = (mult_wr >= pllc_pkg::MULT_MIN) && (mult_wr <= pllc_pkg::MULT_MAX);
  wire wr_csr   = wr_acc && hit_csr;
  wire wr_mult  = wr_acc && hit_mult && mult_in_range;
  wire bad_mult = wr_acc && hit_mult && !mult_in_range;
  wire wr_div0  = wr_acc && hit_div0;
  wire wr_cmd   = wr_acc && hit_cmd;
  wire go_req   = wr_cmd && pwdata[pllc_pkg::CMD_GO_BIT];
  wire clr_err  = wr_cmd && pwdata[pllc_pkg::CMD_CLR_BIT];
  wire rst_next = wr_csr ? pwdata[pllc_pkg::CSR_RST_BIT] : rst_ctl_r;
  wire rst_fall = rst_ctl_r && !rst_next;
  wire rst_short = rst_fall && ((32'(rst_cnt_r) + 32'd1) < pllc_pkg::RESET_MIN_CYCLES);
  wire lock_start = wr_mult || wr_div0 || rst_fall;
  wire apply     = go_pend_r && tick.core;
  wire pend_good = ratio_ok(pend_r.core, pend_r.periph);
  wire align_all = (aln_r == 3'h7);

  // Status words.
  wire [31:0] csr_rd = {25'h000_0000, lock_done, 2'h0, rst_ctl_r, 2'h0, enable_r};
  wire [31:0] stat_rd = {27'h000_0000, serr_r, rerr_r, merr_r, lock_done, go_pend_r};
  wire [31:0] rd_mux =
      hit_pid  ? pllc_pkg::PID_VALUE :
      hit_csr  ? csr_rd :
      hit_mult ? {27'h000_0000, mult_r} :
      hit_div0 ? {27'h000_0000, pre_r} :
      hit_div1 ? {27'h000_0000, pend_r.core} :
      hit_div2 ? {27'h000_0000, pend_r.periph} :
      hit_div3 ? {27'h000_0000, pend_r.memory} :
      hit_stat ? stat_rd :
      hit_aln  ? {29'h0000_0000, aln_r} :
      hit_clock_enable_control ? {29'h0000_0000, clock_enable_control_r} :
      hit_ckst ? {29'h0000_0000, sys_r} :
      hit_syst ? {17'h0_0000, act_r} : 32'h0000_0000;

  // Enables: bypass runs every cycle, loop path follows the ticks.
  wire [2:0] src_en = enable_r ? tick : 3'h7;
  wire [2:0] restart = apply ? (align_all ? 3'h7 : aln_r) : 3'h0;

  // APB answer is prepared in the setup cycle, so access takes one cycle.
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      prdata_r  <= 32'h0000_0000;
      pready_r  <= 1'b0;
      pslverr_r <= 1'b0;
    end else begin
      prdata_r  <= (setup && !pwrite) ? rd_mux : 32'h0000_0000;
      pready_r  <= setup;
      pslverr_r <= setup && !mapped;
    end
  end

  // Loop control: starts in reset and bypassed.
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      rst_ctl_r <= 1'b1;
      enable_r  <= 1'b0;
      rst_cnt_r <= 4'h0;
    end else begin
      rst_ctl_r <= rst_next;
      enable_r  <= wr_csr ? pwdata[pllc_pkg::CSR_EN_BIT] : enable_r;
      rst_cnt_r <= !rst_ctl_r ? 4'h0 : (rst_cnt_r == 4'hf) ? rst_cnt_r : rst_cnt_r + 4'h1;
    end
  end

  // Multiplier refuses factors outside its range and flags the attempt.
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      mult_r <= pllc_pkg::MULT_RESET;
      pre_r  <= pllc_pkg::PRE_RESET;
    end else begin
      mult_r <= wr_mult ? mult_wr : mult_r;
      pre_r  <= wr_div0 ? pwdata[RW-1:0] : pre_r;
    end
  end

  // New post-divider values wait here until go is honoured.
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      pend_r <= {pllc_pkg::MEM_RESET, pllc_pkg::PERI_RESET, pllc_pkg::CORE_RESET};
      act_r  <= {pllc_pkg::MEM_RESET, pllc_pkg::PERI_RESET, pllc_pkg::CORE_RESET};
    end else begin
      pend_r.core   <= (wr_acc && hit_div1) ? pwdata[RW-1:0] : pend_r.core;
      pend_r.periph <= (wr_acc && hit_div2) ? pwdata[RW-1:0] : pend_r.periph;
      pend_r.memory <= (wr_acc && hit_div3) ? pwdata[RW-1:0] : pend_r.memory;
      act_r <= (apply && pend_good) ? pend_r : act_r;
    end
  end

  // Go waits for a core boundary; error flags are sticky, set beats clear.
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      go_pend_r <= 1'b0;
      merr_r    <= 1'b0;
      rerr_r    <= 1'b0;
      serr_r    <= 1'b0;
      applied_r <= 1'b0;
    end else begin
      go_pend_r <= go_req || (go_pend_r && !tick.core);
      merr_r    <= bad_mult || (merr_r && !clr_err);
      rerr_r    <= (apply && !pend_good) || (rerr_r && !clr_err);
      serr_r    <= rst_short || (serr_r && !clr_err);
      applied_r <= applied_r || (apply && pend_good);
    end
  end

  // Registers and outputs.
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      aln_r  <= pllc_pkg::ALN_RESET;
      clock_enable_control_r <= pllc_pkg::CLOCK_ENABLE_CONTROL_RESET;
      sys_r  <= 3'h0;
    end else begin
      aln_r  <= (wr_acc && hit_aln) ? pwdata[2:0] : aln_r;
      clock_enable_control_r <= (wr_acc && hit_clock_enable_control) ? pwdata[2:0] : clock_enable_control_r;
      sys_r  <= src_en & clock_enable_control_r;
    end
  end

  pllc_post_div #(.W(RW)) u_core (
    .clk     (clk),
    .reset_n (reset_n),
    .ratio   (act_r.core),
    .restart (restart[0]),
    .tick_r  (tick.core)
  );

  pllc_post_div #(.W(RW)) u_periph (
    .clk     (clk),
    .reset_n (reset_n),
    .ratio   (act_r.periph),
    .restart (restart[1]),
    .tick_r  (tick.periph)
  );

  pllc_post_div #(.W(RW)) u_memory (
    .clk     (clk),
    .reset_n (reset_n),
    .ratio   (act_r.memory),
    .restart (restart[2]),
    .tick_r  (tick.memory)
  );

  // Lock status only tells software when the wait has passed.
  pllc_lock_timer #(.COUNT(LOCK_CYCLES), .W(16)) u_lock (
    .clk     (clk),
    .reset_n (reset_n),
    .start   (lock_start),
    .done_r  (lock_done)
  );

  assign prdata            = prdata_r;
  assign pready            = pready_r;
  assign pslverr           = pslverr_r;
  assign loop_reset_ctl    = rst_ctl_r;
  assign loop_path_enable  = enable_r;
  assign multiplier_factor = mult_r;
  assign pre_divider       = pre_r;
  assign sys_clk_en        = sys_r;

  a_mult_range: assert property (@(posedge clk) disable iff (!reset_n)
    (mult_r >= pllc_pkg::MULT_MIN) && (mult_r <= pllc_pkg::MULT_MAX))
    else $error("Multiplier left its allowed range.");

  a_mult_refuse: assert property (@(posedge clk) disable iff (!reset_n)
    bad_mult |=> (mult_r == $past(mult_r)) && merr_r)
    else $error("Out of range multiplier was not refused.");

  a_core_default: assert property (@(posedge clk) disable iff (!reset_n)
    !applied_r |-> (act_r.core == pllc_pkg::CORE_RESET))
    else $error("Core ratio is not one before the first go.");

  a_periph_default: assert property (@(posedge clk) disable iff (!reset_n)
    !applied_r |-> (act_r.periph == pllc_pkg::PERI_RESET))
    else $error("Peripheral ratio is not two before the first go.");

  a_mem_default: assert property (@(posedge clk) disable iff (!reset_n)
    !applied_r |-> (act_r.memory == pllc_pkg::MEM_RESET))
    else $error("Memory ratio is not three before the first go.");

  a_periph_ratio: assert property (@(posedge clk) disable iff (!reset_n)
    $changed(act_r) |-> ratio_ok(act_r.core, act_r.periph))
    else $error("Applied peripheral ratio is not a core multiple.");

  a_go_boundary: assert property (@(posedge clk) disable iff (!reset_n)
    $changed(act_r) |-> $past(go_pend_r) && $past(tick.core))
    else $error("Dividers changed without go on a core boundary.");

  a_go_bounded: assert property (@(posedge clk) disable iff (!reset_n)
    go_req && !go_pend_r |=> ##[0:33] !go_pend_r)
    else $error("Go stayed pending past one core period.");

  a_bypass_start: assert property (@(posedge clk) disable iff (!reset_n)
    $past(reset_n) && !enable_r && !$past(enable_r) |-> sys_r == $past(clock_enable_control_r))
    else $error("Bypass does not pass the reference through.");

  a_lock_wait: assert property (@(posedge clk) disable iff (!reset_n)
    lock_start |=> !lock_done [*8])
    else $error("Lock status rose too soon after a change.");

  a_reset_short: assert property (@(posedge clk) disable iff (!reset_n)
    rst_short |=> serr_r)
    else $error("Short loop reset was not flagged.");

  a_reset_loop: assert property (@(posedge clk) disable iff (!reset_n)
    !$past(reset_n) |-> rst_ctl_r && !enable_r)
    else $error("Loop does not start held and bypassed.");

  a_reset_mult: assert property (@(posedge clk) disable iff (!reset_n)
    !$past(reset_n) |-> (mult_r == pllc_pkg::MULT_RESET))
    else $error("Multiplier does not start at thirteen.");

  a_mult_accept: assert property (@(posedge clk) disable iff (!reset_n)
    wr_mult |=> (mult_r == $past(mult_wr)))
    else $error("In range multiplier was not taken.");

  a_merr_sticky: assert property (@(posedge clk) disable iff (!reset_n)
    merr_r && !clr_err |=> merr_r)
    else $error("Multiplier error flag dropped without clear.");

  a_rerr_sticky: assert property (@(posedge clk) disable iff (!reset_n)
    rerr_r && !clr_err |=> rerr_r)
    else $error("Ratio error flag dropped without clear.");

  a_serr_sticky: assert property (@(posedge clk) disable iff (!reset_n)
    serr_r && !clr_err |=> serr_r)
    else $error("Short reset flag dropped without clear.");

  a_ratio_refuse: assert property (@(posedge clk) disable iff (!reset_n)
    apply && !pend_good |=> rerr_r && (act_r == $past(act_r)))
    else $error("Bad peripheral ratio was not refused.");

  a_apply_all: assert property (@(posedge clk) disable iff (!reset_n)
    apply && pend_good |=> (act_r == $past(pend_r)))
    else $error("Pending ratios were not applied together.");

  a_pending_hold: assert property (@(posedge clk) disable iff (!reset_n)
    !(apply && pend_good) |=> (act_r == $past(act_r)))
    else $error("Active ratios changed without an accepted go.");

  a_go_taken: assert property (@(posedge clk) disable iff (!reset_n)
    go_req |=> go_pend_r)
    else $error("Go command was not marked pending.");

  a_go_clears: assert property (@(posedge clk) disable iff (!reset_n)
    apply && !go_req |=> !go_pend_r)
    else $error("Go stayed pending after the core boundary.");

  a_align_restart: assert property (@(posedge clk) disable iff (!reset_n)
    apply && align_all |=> !tick.core && !tick.periph && !tick.memory)
    else $error("Aligned apply did not restart all dividers.");
endmodule : pllc_top

// ---- common/pllc_pkg.sv ----
// Package of the PLL clock controller: register map, field positions,
// reset values, timing counts and the carrier types.
// Assumes a 50 MHz controller clock and an APB register port.
package pllc_pkg;
  localparam logic [31:0] ADDR_PID  = 32'h4100_0000;
  localparam logic [31:0] ADDR_CSR  = 32'h4100_0100;
  localparam logic [31:0] ADDR_MULT = 32'h4100_0110;
  localparam logic [31:0] ADDR_DIV0 = 32'h4100_0114;
  localparam logic [31:0] ADDR_DIV1 = 32'h4100_0118;
  localparam logic [31:0] ADDR_DIV2 = 32'h4100_011C;
  localparam logic [31:0] ADDR_DIV3 = 32'h4100_0120;
  localparam logic [31:0] ADDR_CMD  = 32'h4100_0138;
  localparam logic [31:0] ADDR_STAT = 32'h4100_013C;
  localparam logic [31:0] ADDR_ALN  = 32'h4100_0140;
  localparam logic [31:0] ADDR_CLOCK_ENABLE_CONTROL = 32'h4100_0148;
  localparam logic [31:0] ADDR_CKST = 32'h4100_014C;
  localparam logic [31:0] ADDR_SYST = 32'h4100_0150;

  // Identification value is arbitrary.
  localparam logic [31:0] PID_VALUE = 32'h0001_0203;

  localparam int CSR_EN_BIT   = 0;
  localparam int CSR_RST_BIT  = 3;
  localparam int CSR_LOCK_BIT = 6;
  localparam int CMD_GO_BIT   = 0;
  localparam int CMD_CLR_BIT  = 1;
  localparam int ST_BUSY_BIT  = 0;
  localparam int ST_LOCK_BIT  = 1;
  localparam int ST_MERR_BIT  = 2;
  localparam int ST_RERR_BIT  = 3;
  localparam int ST_SERR_BIT  = 4;

  localparam int RATIO_W = 5;
  localparam int MULT_W  = 5;
  localparam logic [MULT_W-1:0]  MULT_RESET  = 5'h0d;
  localparam logic [MULT_W-1:0]  MULT_MIN    = 5'h04;
  localparam logic [MULT_W-1:0]  MULT_MAX    = 5'h19;
  localparam logic [RATIO_W-1:0] PRE_RESET   = 5'h00;
  localparam logic [RATIO_W-1:0] CORE_RESET  = 5'h00;
  localparam logic [RATIO_W-1:0] PERI_RESET  = 5'h01;
  localparam logic [RATIO_W-1:0] MEM_RESET   = 5'h02;
  localparam logic [2:0]         ALN_RESET   = 3'h0;
  localparam logic [2:0]         CLOCK_ENABLE_CONTROL_RESET  = 3'h7;

  localparam int  CLK_MHZ          = 50;
  localparam int  RESET_MIN_NS     = 125;
  localparam int  RESET_MIN_CYCLES = (RESET_MIN_NS * CLK_MHZ + 999) / 1000;
  localparam real LOCK_TIME_US     = 187.5;
  localparam int  LOCK_CYCLES      = int'($ceil(LOCK_TIME_US * CLK_MHZ));

  typedef struct packed {
    logic memory;
    logic periph;
    logic core;
  } pllc_sysclk_type;

  typedef struct packed {
    logic [RATIO_W-1:0] memory;
    logic [RATIO_W-1:0] periph;
    logic [RATIO_W-1:0] core;
  } pllc_ratio_type;
endpackage : pllc_pkg

// ---- verilog/pllc_post_div.sv ----
// One post-divider: emits a one-cycle tick every (ratio + 1) cycles.
// Assumes the ratio only changes together with a restart pulse.
`timescale 1ns/100ps
module pllc_post_div #(
  parameter int W = 5
) (
  input  wire logic         clk,
  input  wire logic         reset_n,
  input  wire logic [W-1:0] ratio,
  input  wire logic         restart,
  output logic              tick_r
);
  logic [W-1:0] cnt_r;
  wire          at_end = (cnt_r >= ratio);

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      cnt_r  <= '0;
      tick_r <= 1'b0;
    end else begin
      cnt_r  <= (restart || at_end) ? '0 : cnt_r + 1'b1;
      tick_r <= !restart && at_end;
    end
  end
endmodule : pllc_post_div

// ---- verilog/pllc_lock_timer.sv ----
// Lock wait timer: done falls on start and rises COUNT cycles later.
// Assumes start is a one-cycle pulse; a new start restarts the wait.
`timescale 1ns/100ps
module pllc_lock_timer #(
  parameter int COUNT = 9375,
  parameter int W     = 16
) (
  input  wire logic clk,
  input  wire logic reset_n,
  input  wire logic start,
  output logic      done_r
);
  logic [W-1:0] cnt_r;

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      cnt_r  <= '0;
      done_r <= 1'b0;
    end else if (start) begin
      cnt_r  <= W'(COUNT - 1);
      done_r <= 1'b0;
    end else if (!done_r) begin
      cnt_r  <= cnt_r - 1'b1;
      done_r <= (cnt_r == '0);
    end
  end
endmodule : pllc_lock_timer

// ---- verif/pllc_top_test.sv ----
// Self-checking bench of the PLL clock controller, driving its APB port directly.
// Assumes the design carries its own assertions; the lock wait is shortened to 20.
`timescale 1ns/100ps
module pllc_top_test;
  localparam int LOCK = 20;
  logic                      clk;
  logic                      reset_n;
  logic                      psel;
  logic                      penable;
  logic                      pwrite;
  logic [31:0]               paddr;
  logic [31:0]               pwdata;
  logic [31:0]               prdata;
  logic                      pready;
  logic                      pslverr;
  logic                      loop_reset_ctl;
  logic                      loop_path_enable;
  logic [4:0]                multiplier_factor;
  logic [4:0]                pre_divider;
  pllc_pkg::pllc_sysclk_type sys_clk_en;
  logic [31:0]               rd;
  logic                      er;
  int                        miscompares = 0;
  int                        checks = 0;

  pllc_top #(.LOCK_CYCLES(LOCK)) dut (
    .clk(clk), .reset_n(reset_n), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .loop_reset_ctl(loop_reset_ctl), .loop_path_enable(loop_path_enable),
    .multiplier_factor(multiplier_factor), .pre_divider(pre_divider),
    .sys_clk_en(sys_clk_en));

  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  task automatic conclude;
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : conclude

  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    checks++;
    if (got !== exp) begin
      miscompares++;
      $display("wrong value %s expected %h seen %h", name, exp, got);
    end
  endtask : chk

  // The request stands unchanged until pready is sampled high, then is released.
  task automatic apb(input logic w, input logic [31:0] a, input logic [31:0] d);
    @(posedge clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    // Outputs are read 1 ns after the edge, once the design has settled.
    #1;
  endtask : apb

  task automatic rdc(input string name, input logic [31:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0000_0000);
    chk(name, exp, rd);
  endtask : rdc

  task automatic go_wait;
    int n;
    n = 0;
    apb(1'b1, pllc_pkg::ADDR_CMD, 32'h0000_0001);
    do begin
      apb(1'b0, pllc_pkg::ADDR_STAT, 32'h0000_0000);
      n++;
    end while (rd[0] !== 1'b0 && n < 20);
    chk("go pending", 32'h0000_0000, rd[0]);
  endtask : go_wait

  function automatic logic ratio_ok(input logic [4:0] c, input logic [4:0] p);
    return (p + 6'd1 == 2 * (c + 6'd1)) || (p + 6'd1 == 3 * (c + 6'd1)) ||
           (p + 6'd1 == 4 * (c + 6'd1));
  endfunction : ratio_ok

  // Counting over 24 cycles makes the result independent of divider phase.
  task automatic pulses(input logic [2:0] en, input logic [4:0] c, input logic [4:0] p,
                        input logic [4:0] m);
    int nc;
    int np;
    int nm;
    nc = 0;
    np = 0;
    nm = 0;
    repeat (24) begin
      @(posedge clk);
      #1;
      nc += sys_clk_en.core;
      np += sys_clk_en.periph;
      nm += sys_clk_en.memory;
    end
    chk("core pulses", en[0] ? 24 / (c + 1) : 0, nc);
    chk("periph pulses", en[1] ? 24 / (p + 1) : 0, np);
    chk("memory pulses", en[2] ? 24 / (m + 1) : 0, nm);
  endtask : pulses

  initial begin
    repeat (20000) @(posedge clk);
    miscompares++;
    conclude();
  end

  initial begin
    logic [31:0] ra[11];
    logic [31:0] rv[11];
    logic [4:0]  c;
    logic [4:0]  p;
    logic [4:0]  m;
    logic [4:0]  v;
    logic [4:0]  oc;
    logic [4:0]  op;
    logic [4:0]  om;
    logic [4:0]  mult;
    logic        ok;
    psel    = 1'b0;
    penable = 1'b0;
    pwrite  = 1'b0;
    paddr   = 32'h0000_0000;
    pwdata  = 32'h0000_0000;
    reset_n = 1'b0;
    void'($urandom(32'haf00));
    repeat (6) @(posedge clk);
    reset_n <= 1'b1;
    @(posedge clk);
    #1;
    chk("bypass enables", 32'h0000_0007, sys_clk_en);
    chk("loop reset", 32'h0000_0001, loop_reset_ctl);
    chk("loop enable", 32'h0000_0000, loop_path_enable);
    chk("multiplier out", 32'h0000_000D, multiplier_factor);
    apb(1'b1, pllc_pkg::ADDR_PID, 32'h0000_0000);
    ra = '{pllc_pkg::ADDR_PID, pllc_pkg::ADDR_MULT, pllc_pkg::ADDR_DIV0, pllc_pkg::ADDR_DIV1,
           pllc_pkg::ADDR_DIV2, pllc_pkg::ADDR_DIV3, pllc_pkg::ADDR_ALN, pllc_pkg::ADDR_CLOCK_ENABLE_CONTROL,
           pllc_pkg::ADDR_SYST, pllc_pkg::ADDR_CKST, 32'h4100_0104};
    rv = '{pllc_pkg::PID_VALUE, 32'h0000_000D, 32'h0000_0000, 32'h0000_0000, 32'h0000_0001,
           32'h0000_0002, 32'h0000_0000, 32'h0000_0007, 32'h0000_0820, 32'h0000_0007,
           32'h0000_0000};
    for (int i = 0; i < 11; i++) begin
      rdc("reset register", ra[i], rv[i]);
      chk("slave error", i == 10, er);
    end
    mult = 5'h0d;
    for (int i = 0; i < 14; i++) begin
      v = (i < 4) ? 5'(3 + 22 * (i / 2) + i % 2) : 5'($urandom_range(31, 0));
      ok = v >= 5'h04 && v <= 5'h19;
      apb(1'b1, pllc_pkg::ADDR_CMD, 32'h0000_0002);
      apb(1'b1, pllc_pkg::ADDR_MULT, {27'h0, v});
      mult = ok ? v : mult;
      apb(1'b0, pllc_pkg::ADDR_STAT, 32'h0000_0000);
      chk("range error", !ok, rd[2]);
      if (ok) chk("lock after change", 32'h0000_0000, rd[1]);
      chk("multiplier out", mult, multiplier_factor);
    end
    repeat (LOCK + 5) @(posedge clk);
    apb(1'b0, pllc_pkg::ADDR_STAT, 32'h0000_0000);
    chk("lock done", 32'h0000_0001, rd[1]);
    // Release the power-on loop reset and clear old flags before the short pulse.
    apb(1'b1, pllc_pkg::ADDR_CSR, 32'h0000_0000);
    apb(1'b1, pllc_pkg::ADDR_CMD, 32'h0000_0002);
    apb(1'b1, pllc_pkg::ADDR_CSR, 32'h0000_0008);
    apb(1'b1, pllc_pkg::ADDR_CSR, 32'h0000_0000);
    chk("loop reset", 32'h0000_0000, loop_reset_ctl);
    rdc("short reset", pllc_pkg::ADDR_STAT, 32'h0000_0010);
    apb(1'b1, pllc_pkg::ADDR_CMD, 32'h0000_0002);
    apb(1'b1, pllc_pkg::ADDR_CSR, 32'h0000_0008);
    repeat (10) @(posedge clk);
    apb(1'b1, pllc_pkg::ADDR_CSR, 32'h0000_0000);
    rdc("long reset", pllc_pkg::ADDR_STAT, 32'h0000_0000);
    apb(1'b1, pllc_pkg::ADDR_ALN, 32'h0000_0007);
    oc = 5'h00;
    op = 5'h01;
    om = 5'h02;
    repeat (8) begin
      c = 5'($urandom_range(3, 0));
      p = 5'($urandom_range(4, 1) * (c + 1) - 1);
      m = 5'($urandom_range(7, 0));
      apb(1'b1, pllc_pkg::ADDR_CMD, 32'h0000_0002);
      apb(1'b1, pllc_pkg::ADDR_DIV1, {27'h0, c});
      apb(1'b1, pllc_pkg::ADDR_DIV2, {27'h0, p});
      apb(1'b1, pllc_pkg::ADDR_DIV3, {27'h0, m});
      rdc("pending kept", pllc_pkg::ADDR_SYST, {17'h0, om, op, oc});
      rdc("pending readback", pllc_pkg::ADDR_DIV2, {27'h0, p});
      go_wait();
      ok = ratio_ok(c, p);
      if (ok) {om, op, oc} = {m, p, c};
      rdc("active ratios", pllc_pkg::ADDR_SYST, {17'h0, om, op, oc});
      apb(1'b0, pllc_pkg::ADDR_STAT, 32'h0000_0000);
      chk("ratio error", !ok, rd[3]);
    end
    apb(1'b1, pllc_pkg::ADDR_DIV1, 32'h0000_0001);
    apb(1'b1, pllc_pkg::ADDR_DIV2, 32'h0000_0003);
    apb(1'b1, pllc_pkg::ADDR_DIV3, 32'h0000_0002);
    go_wait();
    // A 25 MHz reference times 20 keeps the loop output at 500 MHz.
    apb(1'b1, pllc_pkg::ADDR_DIV0, 32'h0000_0001);
    chk("pre divider", 32'h0000_0001, pre_divider);
    apb(1'b1, pllc_pkg::ADDR_MULT, 32'h0000_0014);
    repeat (LOCK + 5) @(posedge clk);
    apb(1'b0, pllc_pkg::ADDR_STAT, 32'h0000_0000);
    chk("lock before enable", 32'h0000_0001, rd[1]);
    apb(1'b1, pllc_pkg::ADDR_CLOCK_ENABLE_CONTROL, 32'h0000_0005);
    apb(1'b1, pllc_pkg::ADDR_CSR, 32'h0000_0001);
    chk("loop enable", 32'h0000_0001, loop_path_enable);
    pulses(3'h5, 5'h01, 5'h03, 5'h02);
    apb(1'b1, pllc_pkg::ADDR_CLOCK_ENABLE_CONTROL, 32'h0000_0007);
    pulses(3'h7, 5'h01, 5'h03, 5'h02);
    conclude();
  end
endmodule : pllc_top_test
